//--- dv/gdp_pad_model.sv
// Pad model for the GPIO block: resolves each pin from drive, source and pull-up.
// Assumes one clock; a pin that nothing holds shows a level that flips each cycle.
`timescale 1ns/100ps
`default_nettype none
module gdp_pad_model
  import gdp_pkg::*;
(
  input wire logic mclk_i,                    // System clock
  input wire logic [NPORT-1:0][7:0] oe_i,     // Block drive enables
  input wire logic [NPORT-1:0][7:0] out_i,    // Block drive data
  input wire logic [NPORT-1:0][7:0] pu_i,     // Pull-up enables
  input wire logic [NPORT-1:0][7:0] src_en_i, // Outside source active
  input wire logic [NPORT-1:0][7:0] src_i,    // Outside source level
  output logic [NPORT-1:0][7:0] pad_o         // Resolved pad level
);
  logic [NPORT-1:0][7:0] flt_r = '0;
  // Floating level keeps changing so a lost pull-up cannot pass by luck
  always @(posedge mclk_i) flt_r <= ~flt_r;
  // Block drive wins, then the outside source, then the pull-up
  always_comb begin
    pad_o = (oe_i & out_i) | (~oe_i & src_en_i & src_i) | (~oe_i & ~src_en_i & pu_i)
      | (~oe_i & ~src_en_i & ~pu_i & flt_r);
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the GPIO direction and pull-up block.
// Assumes the pad model on the pins; reads are checked one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import gdp_pkg::*;
  logic mclk_i = 0, resetn_i = 0, reg_wr_i = 0, bit_set_i = 0, bit_clr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o, d, e, q[$];
  logic [2:0] bit_sel_i = '0;
  logic ext_reset_en_i = 0, wake_req_o, rd_d = 0;
  logic [NPORT-1:0][7:0] pin_in_i, pin_out_o, pin_oe_o, pin_pu_o, src_en = '1, src = '0;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, wk = 0, w0, s, c;
  always #50 mclk_i = ~mclk_i;
  gdp_gpio dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .bit_set_i(bit_set_i),
    .bit_clr_i(bit_clr_i), .bit_sel_i(bit_sel_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ext_reset_en_i(ext_reset_en_i), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o), .wake_req_o(wake_req_o));
  gdp_pad_model pad_u (.mclk_i(mclk_i), .oe_i(pin_oe_o), .out_i(pin_out_o), .pu_i(pin_pu_o),
    .src_en_i(src_en), .src_i(src), .pad_o(pin_in_i));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One strobe per call, held to its taking edge, then an idle edge
  task automatic op(input logic [3:0] k, input logic [7:0] a, input logic [7:0] dv);
    @(posedge mclk_i);
    {reg_rd_i, bit_clr_i, bit_set_i, reg_wr_i} <= k;
    reg_addr_i <= a;
    reg_wdata_i <= dv;
    bit_sel_i <= dv[2:0];
    @(posedge mclk_i);
    {reg_rd_i, bit_clr_i, bit_set_i, reg_wr_i} <= 4'h0;
    // Outputs launched at the taking edge are only looked at once settled
    @(negedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    q.push_back(exp);
    op(4'h8, a, 8'h00);
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Watchers: read data, wake pulses and the hang limit
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rd_d) chk(reg_rdata_o, q.pop_front());
    rd_d <= reg_rd_i;
    if (wake_req_o === 1'b1) wk++;
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence, one pass per port
  // ----------------------------------------------------------------
  initial begin
    d = $urandom(32'h1632);
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(negedge mclk_i);
    chk(pin_pu_o[0], INPUT_ONLY_MASK);
    for (int k = 0; k < NPORT; k++) begin
      chk(pin_oe_o[k], 8'h00);
      rd(DIR_ADDR[k], DIR_RST);
      d = $urandom();
      op(4'h1, DIR_ADDR[k], d);
      chk(pin_oe_o[k], d & DIR_MASK[k]);
      rd(DIR_ADDR[k], d & DIR_MASK[k]);
      op(4'h1, PU_ADDR[k], 8'hFF);
      e = (k == 0) ? INPUT_ONLY_MASK : 8'h00;
      chk(pin_pu_o[k], (~d & PU_MASK[k]) | e);
      rd(PU_ADDR[k], 8'h00);
      e = $urandom();
      op(4'h1, DATA_ADDR[k], e);
      chk(pin_out_o[k] & d & DIR_MASK[k], e & d & DIR_MASK[k]);
      // Set one random bit and clear one random bit, maybe the same, without a byte rewrite
      s = $urandom_range(7);
      c = $urandom_range(7);
      op(4'h2, DIR_ADDR[k], 8'(s));
      op(4'h4, DIR_ADDR[k], 8'(c));
      chk(pin_oe_o[k], (d | (8'h01 << s)) & ~(8'h01 << c) & DIR_MASK[k]);
      op(4'h1, DIR_ADDR[k], 8'h00);
      @(posedge mclk_i);
      src[k] <= 8'($urandom());
      repeat (6) @(posedge mclk_i);
      rd(DATA_ADDR[k], src[k] & DATA_MASK[k]);
      // Outside source let go: only the pull-ups hold the input pins high
      @(posedge mclk_i);
      src_en[k] <= 8'h00;
      repeat (6) @(posedge mclk_i);
      rd(DATA_ADDR[k], DATA_MASK[k]);
      @(posedge mclk_i);
      src_en[k] <= 8'hFF;
    end
    // Pad low on the input-only pin, yet it reads high with the option on
    @(posedge mclk_i);
    src[0] <= 8'h00;
    ext_reset_en_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rd(DATA_ADDR[0], 8'h10);
    // Wake only from the enabled port 1 pin, and not once disabled
    for (int n = 1; n >= 0; n--) begin
      op(4'h1, WAKE_ADDR, 8'(n));
      w0 = wk;
      @(posedge mclk_i);
      src[1][0] <= ~src[1][0];
      repeat (8) @(posedge mclk_i);
      chk(8'(wk - w0), 8'(n));
    end
    repeat (2) @(posedge mclk_i);
    complete_run();
  end
endmodule
`default_nettype wire

//--- logic/gdp_gpio.sv
// GPIO direction and pull-up block for ports 0, 1, 2 and 5.
// Assumes a core-side register port with byte writes and single-bit set/clear,
// reads answered one cycle later, and pads that resolve out/oe/pull-up.
`timescale 1ns/100ps
`default_nettype none
module gdp_gpio
  import gdp_pkg::*;
(
  input wire logic mclk_i,                      // System clock, 10 MHz
  input wire logic resetn_i,                    // Asynchronous reset, active low
  input wire logic [7:0] reg_addr_i,            // Register address
  input wire logic reg_wr_i,                    // Byte write strobe
  input wire logic [7:0] reg_wdata_i,           // Byte write data
  input wire logic bit_set_i,                   // Single-bit set strobe
  input wire logic bit_clr_i,                   // Single-bit clear strobe
  input wire logic [2:0] bit_sel_i,             // Bit number for set/clear
  input wire logic reg_rd_i,                    // Read strobe
  output logic [7:0] reg_rdata_o,               // Read data, one cycle later
  input wire logic ext_reset_en_i,              // External reset option, static
  input wire logic [NPORT-1:0][7:0] pin_in_i,   // Pad input levels
  output logic [NPORT-1:0][7:0] pin_out_o,      // Pad output data
  output logic [NPORT-1:0][7:0] pin_oe_o,       // Pad output enable, high drives
  output logic [NPORT-1:0][7:0] pin_pu_o,       // Pad pull-up enable
  output logic wake_req_o                       // Wakeup request pulse
);

  gdp_state_t s_r;
  gdp_state_t s_nxt;
  logic [NPORT-1:0][7:0] pin_sync;
  logic [7:0] bit_mask;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One update path for every writable register, so set/clear behave alike
  function automatic logic [7:0] reg_upd(input logic [7:0] old, input logic hit,
                                         input logic wr, input logic set,
                                         input logic clr, input logic [7:0] wdata,
                                         input logic [7:0] bm, input logic [7:0] mask);
    logic [7:0] v;
    v = old;
    if (hit && wr) begin
      v = wdata;
    end else if (hit && set) begin
      v = old | bm;
    end else if (hit && clr) begin
      v = old & ~bm;
    end
    return v & mask;
  endfunction

  // Pin readback: latch for outputs, filtered pad for inputs
  function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] dat,
                                          input logic [7:0] pad, input logic [7:0] mask);
    return ((dat & dir) | (pad & ~dir)) & mask;
  endfunction

  // ----------------------------------------------------------------
  // Pad input filtering
  // ----------------------------------------------------------------
  gdp_pin_sync #(
    .W(NPORT * 8)
  ) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .d_i(pin_in_i),
    .q_o(pin_sync)
  );

  assign bit_mask = 8'h01 << bit_sel_i;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] view;
    view = 8'h00;
    s_nxt = s_r;
    s_nxt.rdata = s_r.rdata;
    for (int p = 0; p < NPORT; p++) begin
      // Per-pin direction, masked to implemented bits; pin 4 of port 0 has none
      s_nxt.dir[p] = reg_upd(s_r.dir[p], reg_addr_i == DIR_ADDR[p], reg_wr_i,
                             bit_set_i, bit_clr_i, reg_wdata_i, bit_mask,
                             DIR_MASK[p]);
      s_nxt.pu[p] = reg_upd(s_r.pu[p], reg_addr_i == PU_ADDR[p], reg_wr_i,
                            bit_set_i, bit_clr_i, reg_wdata_i, bit_mask,
                            PU_MASK[p]);
      s_nxt.dat[p] = reg_upd(s_r.dat[p], reg_addr_i == DATA_ADDR[p], reg_wr_i,
                             bit_set_i, bit_clr_i, reg_wdata_i, bit_mask,
                             DATA_MASK[p] & ~(p == 0 ? INPUT_ONLY_MASK : 8'h00));
      // Pull-up disabled while the pin drives, avoids fighting the driver
      s_nxt.pu_eff[p] = s_nxt.pu[p] & ~s_nxt.dir[p];
    end
    s_nxt.pu_eff[0] = s_nxt.pu_eff[0] | INPUT_ONLY_MASK;
    s_nxt.wake_en = reg_upd(s_r.wake_en, reg_addr_i == WAKE_ADDR, reg_wr_i,
                            bit_set_i, bit_clr_i, reg_wdata_i, bit_mask, 8'hFF);

    // Wakeup on any level change of an enabled port 1 input pin
    // p1_prev and the filter both reset low, so reset makes no false wake edge
    s_nxt.p1_prev = pin_sync[P1_IDX];
    s_nxt.wake_req = |((pin_sync[P1_IDX] ^ s_r.p1_prev) & s_r.wake_en
                       & ~s_r.dir[P1_IDX]);

    // Read mux; pull-up registers are write-only and read zero
    if (reg_rd_i) begin
      s_nxt.rdata = 8'h00;
      for (int p = 0; p < NPORT; p++) begin
        if (reg_addr_i == DIR_ADDR[p]) begin
          s_nxt.rdata = s_r.dir[p];
        end
        if (reg_addr_i == DATA_ADDR[p]) begin
          view = pin_view(s_r.dir[p], s_r.dat[p], pin_sync[p], DATA_MASK[p]);
          if (p == 0 && ext_reset_en_i) begin
            view = view | INPUT_ONLY_MASK;
          end
          s_nxt.rdata = view;
        end
      end
      if (reg_addr_i == WAKE_ADDR) begin
        s_nxt.rdata = s_r.wake_en;
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r.dir <= {NPORT{DIR_RST}};
      s_r.pu <= {NPORT{PU_RST}};
      s_r.pu_eff <= {{(NPORT-1){PU_RST}}, INPUT_ONLY_MASK};
      s_r.dat <= {NPORT{DATA_RST}};
      s_r.wake_en <= WAKE_RST;
      s_r.p1_prev <= 8'h00;
      s_r.wake_req <= 1'b0;
      s_r.rdata <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign pin_oe_o = s_r.dir;
  assign pin_out_o = s_r.dat;
  assign pin_pu_o = s_r.pu_eff;
  assign reg_rdata_o = s_r.rdata;
  assign wake_req_o = s_r.wake_req;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Antecedents follow traffic the bench really drives, so each property fires

  dir_byte_write_a: assert property (
    reg_wr_i && reg_addr_i == DIR_ADDR[1] |=> pin_oe_o[1] == $past(reg_wdata_i))
    else $error("port 1 direction byte write not applied");

  input_only_dir_a: assert property (
    reg_wr_i && reg_addr_i == DIR_ADDR[0] |=> !pin_oe_o[0][4] && pin_oe_o[0][7:4] == 4'h0)
    else $error("port 0 pin 4 became an output");

  input_only_pu_a: assert property (
    (reg_wr_i || bit_clr_i) && reg_addr_i == PU_ADDR[0] |=> pin_pu_o[0][4])
    else $error("port 0 pin 4 pull-up dropped");

  bit_set_a: assert property (
    bit_set_i && !reg_wr_i && reg_addr_i == DIR_ADDR[1]
    |=> pin_oe_o[1] == ($past(pin_oe_o[1]) | (8'h01 << $past(bit_sel_i))))
    else $error("direction bit set touched other bits");

  bit_clear_a: assert property (
    bit_clr_i && !bit_set_i && !reg_wr_i && reg_addr_i == DIR_ADDR[1]
    |=> pin_oe_o[1] == ($past(pin_oe_o[1]) & ~(8'h01 << $past(bit_sel_i))))
    else $error("direction bit clear touched other bits");

  pullup_write_a: assert property (
    reg_wr_i && reg_addr_i == PU_ADDR[1]
    |=> pin_pu_o[1] == ($past(reg_wdata_i) & ~pin_oe_o[1]))
    else $error("port 1 pull-up write not applied");

  reset_read_a: assert property (
    reg_rd_i && reg_addr_i == DATA_ADDR[0] && ext_reset_en_i |=> reg_rdata_o[4])
    else $error("pin 4 did not read one under external reset option");

  wake_gate_a: assert property (
    s_r.wake_en == 8'h00 ##1 s_r.wake_en == 8'h00 |-> !wake_req_o)
    else $error("wakeup raised with all enables clear");

  pullup_output_a: assert property (
    (pin_pu_o[2] & pin_oe_o[2]) == 8'h00 && (pin_pu_o[1] & pin_oe_o[1]) == 8'h00)
    else $error("pull-up applied on a driving pin");

  data_write_a: assert property (
    reg_wr_i && reg_addr_i == DATA_ADDR[2]
    |=> pin_out_o[2] == ($past(reg_wdata_i) & DATA_MASK[2]))
    else $error("port 2 output latch write not applied");

  pullup_read_a: assert property (
    reg_rd_i && reg_addr_i == PU_ADDR[1] |=> reg_rdata_o == 8'h00)
    else $error("write-only pull-up register read nonzero");

  dir_write_c: cover property (reg_wr_i && reg_addr_i == DIR_ADDR[3] ##1 pin_oe_o[3] != 8'h00);
  bit_set_c: cover property (bit_set_i && reg_addr_i == DIR_ADDR[0]);
  wake_c: cover property (wake_req_o);
  pad_read_c: cover property (reg_rd_i && reg_addr_i == DATA_ADDR[1] && pin_oe_o[1] == 8'h00);

endmodule
`default_nettype wire

//--- logic/gdp_pin_sync.sv
// Pad input filter for the GPIO block.
// Three flip-flops and an output flop; the output follows once the second and third agree.
// Assumes the inputs are asynchronous to mclk_i.
`timescale 1ns/100ps
`default_nettype none
module gdp_pin_sync #(
  parameter int W = 8
) (
  input wire logic mclk_i,           // System clock
  input wire logic resetn_i,         // Asynchronous reset, active low
  input wire logic [W-1:0] d_i,      // Raw pad levels
  output logic [W-1:0] q_o           // Filtered levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } gdp_sync_t;

  gdp_sync_t s_r;
  gdp_sync_t s_nxt;

  // ----------------------------------------------------------------
  // Filter: s1 feeds s2 only, so metastability never reaches logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < W; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.q[i] = s_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.q;

endmodule
`default_nettype wire

//--- logic/gdp_pkg.sv
// Package for the GPIO direction / pull-up block.
// Holds register offsets, implemented-bit masks, reset values and the state type.
// Assumes the core presents an 8-bit register address space.
package gdp_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int NPORT = 4;                // Ports 0, 1, 2, 5 at index 0..3
  localparam int P1_IDX = 1;               // Index of port 1 (wakeup port)
  localparam int INPUT_ONLY_BIT = 4;       // Input-only pin on port 0

  // ----------------------------------------------------------------
  // Register offsets, index order is port 0, 1, 2, 5 from the right
  // ----------------------------------------------------------------
  localparam logic [NPORT-1:0][7:0] DIR_ADDR = {8'hC5, 8'hC2, 8'hC1, 8'hB8};
  localparam logic [NPORT-1:0][7:0] PU_ADDR = {8'hE5, 8'hE2, 8'hE1, 8'hE0};
  localparam logic [NPORT-1:0][7:0] DATA_ADDR = {8'hD5, 8'hD2, 8'hD1, 8'hD0};
  localparam logic [7:0] WAKE_ADDR = 8'hC0;

  // ----------------------------------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [NPORT-1:0][7:0] DIR_MASK = {8'h1F, 8'h3F, 8'hFF, 8'h0F};
  localparam logic [NPORT-1:0][7:0] PU_MASK = {8'h1F, 8'h3F, 8'hFF, 8'h0F};
  localparam logic [NPORT-1:0][7:0] DATA_MASK = {8'h1F, 8'h3F, 8'hFF, 8'h1F};
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] PU_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [7:0] INPUT_ONLY_MASK = 8'h10;  // Bit 4 of port 0

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NPORT-1:0][7:0] dir;      // Direction, 1 = output
    logic [NPORT-1:0][7:0] pu;       // Pull-up enables as written
    logic [NPORT-1:0][7:0] pu_eff;   // Pull-ups applied to the pads
    logic [NPORT-1:0][7:0] dat;      // Output data latches
    logic [7:0] wake_en;             // Port 1 wakeup enables
    logic [7:0] p1_prev;             // Last filtered port 1 level
    logic wake_req;                  // Wakeup request pulse
    logic [7:0] rdata;               // Read data
  } gdp_state_t;

endpackage
